// [pfc_regs.sv]
// Loop-filter, calibration-wait, stored CRC and program count registers.
`timescale 1ns/100ps
module pfc_regs
  import pfc_pkg::*;
#(
  parameter int VCO_WAIT_MAX_CYC = PFC_VCO_US[3] * PFC_CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register port from the serial interface
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rd_valid_o,
  output logic reg_busy_o,
  // EEPROM loader and programmer
  input wire logic load_request_bit_i,
  input wire logic load_done_i,
  input wire pfc_image_t load_image_i,
  input wire logic crc_mismatch_i,
  input wire logic prog_done_i,
  output logic load_start_o,
  output logic [7:0] prog_count_next_o,
  output logic prog_count_we_o,
  output logic crc_mismatch_flag_o,
  // Analog settings and calibration
  output logic [6:0] filter_r3_select_o,
  output logic [2:0] filter_c3_select_o,
  input wire logic cal_wait_start_i,
  input wire logic cal_wait_vco_i,
  output logic cal_wait_done_o
);
  typedef enum logic [1:0] {PFC_ST_BOOT, PFC_ST_LOAD, PFC_ST_IDLE} pfc_st_t;

  // ==========================================================================
  // Storage
  pfc_st_t state_ff, nxt_state;
  logic [6:0] filter_r3_select_ff;
  logic [2:0] filter_c3_select_ff;
  logic [1:0] closed_loop_wait_code_ff;
  logic [1:0] vco_settle_wait_code_ff;
  logic [7:0] stored_crc_value_ff;
  logic [7:0] program_cycle_count_ff;
  logic crc_mismatch_flag_ff;
  logic [7:0] rdata_ff;
  logic rd_valid_ff;
  logic [23:0] wait_cnt_ff;
  logic wait_run_ff;
  logic wait_done_ff;

  // Decoding and the next count.
  wire loading = (state_ff != PFC_ST_IDLE);
  wire wr_r3 = reg_wr_i && !loading && (reg_addr_i == PFC_OFS_R3);
  wire wr_c3 = reg_wr_i && !loading && (reg_addr_i == PFC_OFS_C3);
  wire wr_cal = reg_wr_i && !loading && (reg_addr_i == PFC_OFS_CAL);
  wire cnt_sat = (program_cycle_count_ff == PFC_CNT_MAX);
  wire [7:0] cnt_inc = cnt_sat ? program_cycle_count_ff
                     : program_cycle_count_ff + 8'h01;
  wire load_go = (state_ff == PFC_ST_IDLE) && load_request_bit_i;

  // Read multiplexer; reserved bits and unmapped offsets return zero.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr_i == PFC_OFS_R3) begin
      rd_mux = {1'b0, filter_r3_select_ff};
    end else if (reg_addr_i == PFC_OFS_C3) begin
      rd_mux = {5'h00, filter_c3_select_ff};
    end else if (reg_addr_i == PFC_OFS_CAL) begin
      rd_mux = {4'h0, closed_loop_wait_code_ff, vco_settle_wait_code_ff};
    end else if (reg_addr_i == PFC_OFS_SCRC) begin
      rd_mux = stored_crc_value_ff;
    end else if (reg_addr_i == PFC_OFS_CNT) begin
      rd_mux = program_cycle_count_ff;
    end
  end

  // Load sequencer: boot starts a load, a request starts another.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PFC_ST_BOOT: nxt_state = PFC_ST_LOAD;
      PFC_ST_LOAD: if (load_done_i) nxt_state = PFC_ST_IDLE;
      PFC_ST_IDLE: if (load_go) nxt_state = PFC_ST_LOAD;
      default: nxt_state = PFC_ST_IDLE;
    endcase
  end

  // Sequencer state.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= PFC_ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Host-writable fields, overwritten by a completed EEPROM load.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filter_r3_select_ff <= PFC_RST_R3;
      filter_c3_select_ff <= PFC_RST_C3;
      closed_loop_wait_code_ff <= PFC_RST_CLSD;
      vco_settle_wait_code_ff <= PFC_RST_VCO;
    end else if ((state_ff == PFC_ST_LOAD) && load_done_i) begin
      filter_r3_select_ff <= load_image_i.r3;
      filter_c3_select_ff <= load_image_i.c3;
      closed_loop_wait_code_ff <= load_image_i.clsd;
      vco_settle_wait_code_ff <= load_image_i.vco;
    end else begin
      if (wr_r3) filter_r3_select_ff <= reg_wdata_i[6:0];
      if (wr_c3) filter_c3_select_ff <= reg_wdata_i[2:0];
      if (wr_cal) begin
        closed_loop_wait_code_ff <= reg_wdata_i[3:2];
        vco_settle_wait_code_ff <= reg_wdata_i[1:0];
      end
    end
  end

  // Read-only EEPROM-backed values and the CRC error flag.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stored_crc_value_ff <= PFC_RST_SCRC;
      program_cycle_count_ff <= PFC_RST_CNT;
      crc_mismatch_flag_ff <= 1'b0;
    end else if ((state_ff == PFC_ST_LOAD) && load_done_i) begin
      stored_crc_value_ff <= load_image_i.scrc;
      program_cycle_count_ff <= load_image_i.cnt;
      crc_mismatch_flag_ff <= crc_mismatch_i;
    end else if (prog_done_i) begin
      program_cycle_count_ff <= cnt_inc;
    end
  end

  // Registered read data; reads made while a load runs are dropped, not answered.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= reg_rd_i && !loading;
      if (reg_rd_i && !loading) rdata_ff <= rd_mux;
    end
  end

  // Calibration wait timer, length chosen by the current wait code.
  wire [23:0] clsd_cyc = 24'(PFC_CLSD_US[closed_loop_wait_code_ff]
                             * PFC_CLK_MHZ);
  wire [23:0] vco_cyc = 24'(PFC_VCO_US[vco_settle_wait_code_ff]
                            * PFC_CLK_MHZ);
  wire [23:0] wait_len = cal_wait_vco_i ? vco_cyc : clsd_cyc;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt_ff <= 24'h000000;
      wait_run_ff <= 1'b0;
      wait_done_ff <= 1'b0;
    end else begin
      wait_done_ff <= 1'b0;
      if (cal_wait_start_i) begin
        wait_cnt_ff <= wait_len - 24'h000001;
        wait_run_ff <= 1'b1;
      end else if (wait_run_ff) begin
        wait_cnt_ff <= wait_cnt_ff - 24'h000001;
        if (wait_cnt_ff == 24'h000000) begin
          wait_run_ff <= 1'b0;
          wait_done_ff <= 1'b1;
        end
      end
    end
  end

  // Outputs.
  assign reg_rdata_o = rdata_ff;
  assign reg_rd_valid_o = rd_valid_ff;
  assign reg_busy_o = loading;
  assign load_start_o = (state_ff == PFC_ST_BOOT) || load_go;
  assign prog_count_next_o = cnt_inc;
  assign prog_count_we_o = prog_done_i;
  assign crc_mismatch_flag_o = crc_mismatch_flag_ff;
  assign filter_r3_select_o = filter_r3_select_ff;
  assign filter_c3_select_o = filter_c3_select_ff;
  assign cal_wait_done_o = wait_done_ff;

  // ==========================================================================
  // Checks
  chk_count_saturate: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (prog_done_i && cnt_sat && !(state_ff == PFC_ST_LOAD && load_done_i))
    |=> (program_cycle_count_ff == PFC_CNT_MAX))
    else $error("Program count left saturation.");
  chk_count_incr: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (prog_done_i && !cnt_sat && !(state_ff == PFC_ST_LOAD && load_done_i))
    |=> (program_cycle_count_ff == $past(program_cycle_count_ff) + 8'h01))
    else $error("Program count did not step by one.");
  chk_count_ro: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (!prog_done_i && !load_done_i) |=> $stable(program_cycle_count_ff))
    else $error("Program count changed without cause.");
  chk_count_reload: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (state_ff == PFC_ST_LOAD && load_done_i)
    |=> (program_cycle_count_ff == $past(load_image_i.cnt)))
    else $error("Program count not reloaded.");
  chk_crc_flag: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (state_ff == PFC_ST_LOAD && load_done_i)
    |=> (crc_mismatch_flag_o == $past(crc_mismatch_i)))
    else $error("CRC flag does not follow the load.");
  chk_read_block: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (reg_rd_i && loading) |=> !reg_rd_valid_o)
    else $error("Read answered during load.");
  chk_boot_load: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (state_ff == PFC_ST_BOOT) |-> load_start_o ##1 reg_busy_o)
    else $error("No load after reset.");
  chk_reserved_zero: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (reg_rd_i && !loading && reg_addr_i == PFC_OFS_C3)
    |=> (reg_rdata_o[7:3] == 5'h00))
    else $error("Reserved bits read nonzero.");
  chk_c3_write: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (wr_c3 && !load_done_i)
    |=> (filter_c3_select_o == $past(reg_wdata_i[2:0])))
    else $error("C3 code not written.");

  // Helper count of the running wait, so a long wait needs no long delay.
  logic [23:0] chk_wait_cyc_ff;
  logic chk_vco0_ff;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_wait_cyc_ff <= 24'h000000;
      chk_vco0_ff <= 1'b0;
    end else if (cal_wait_start_i) begin
      chk_wait_cyc_ff <= 24'h000000;
      chk_vco0_ff <= cal_wait_vco_i && (vco_settle_wait_code_ff == 2'h0);
    end else if (wait_run_ff) begin
      chk_wait_cyc_ff <= chk_wait_cyc_ff + 24'h000001;
    end
  end
  chk_wait_len: assert property (@(posedge sys_clk_i)
    disable iff (!arst_n_i)
    (cal_wait_done_o && chk_vco0_ff)
    |-> (chk_wait_cyc_ff == 24'(PFC_VCO_US[0] * PFC_CLK_MHZ)))
    else $error("VCO wait of code 0 has wrong length.");
endmodule // pfc_regs

// [pfc_pkg.sv]
// Package for the loop-filter, calibration-wait and EEPROM count registers.
package pfc_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PFC_OFS_R3 = 8'h26;
  localparam logic [7:0] PFC_OFS_C3 = 8'h27;
  localparam logic [7:0] PFC_OFS_CAL = 8'h2A;
  localparam logic [7:0] PFC_OFS_SCRC = 8'h2F;
  localparam logic [7:0] PFC_OFS_CNT = 8'h30;
  // ==========================================================================
  // Reset values
  localparam logic [6:0] PFC_RST_R3 = 7'h00;
  localparam logic [2:0] PFC_RST_C3 = 3'h7;
  localparam logic [1:0] PFC_RST_CLSD = 2'h2;
  localparam logic [1:0] PFC_RST_VCO = 2'h1;
  localparam logic [7:0] PFC_RST_SCRC = 8'h00;
  localparam logic [7:0] PFC_RST_CNT = 8'h01;
  localparam logic [7:0] PFC_CNT_MAX = 8'hFF;
  // ==========================================================================
  // Clock and wait times
  localparam int PFC_CLK_MHZ = 25;
  localparam int PFC_CLSD_US [4] = '{150, 300, 500, 2000};
  localparam int PFC_VCO_US [4] = '{20, 400, 4000, 10000};
  // ==========================================================================
  // Image of the stored fields carried from the EEPROM loader.
  typedef struct packed {
    logic [6:0] r3;
    logic [2:0] c3;
    logic [1:0] clsd;
    logic [1:0] vco;
    logic [7:0] scrc;
    logic [7:0] cnt;
  } pfc_image_t;
endpackage : pfc_pkg

// [pfc_loader_model.sv]
// Behavioural EEPROM loader that answers load requests of the register bank.
`timescale 1ns/100ps
module pfc_loader_model
  import pfc_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Request and stored contents
  input wire logic load_start_i,
  input wire pfc_image_t img_i,
  input wire logic crc_i,
  // Answer to the register bank
  output logic load_done_o,
  output pfc_image_t img_o,
  output logic crc_o
);
  logic [2:0] dly_ff = 3'h0;
  logic load_done_ff = 1'b0;
  // Answers a load after a few cycles; a busy loader ignores new starts.
  always @(posedge sys_clk_i) begin
    load_done_ff <= 1'b0;
    if (dly_ff == 3'h1) load_done_ff <= 1'b1;
    if (dly_ff != 3'h0) dly_ff <= dly_ff - 3'h1;
    else if (load_start_i && !load_done_ff) dly_ff <= 3'h4;
  end
  // Outside the done pulse the data lines show no valid image.
  assign load_done_o = load_done_ff;
  assign img_o = load_done_ff ? img_i : ~img_i;
  assign crc_o = load_done_ff ? crc_i : ~crc_i;
endmodule // pfc_loader_model

// [tb.sv]
// Self-checking testbench for the loop-filter and EEPROM count registers.
`timescale 1ns/100ps
module tb;
  import pfc_pkg::*;
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
  logic lreq = 1'b0, pdone = 1'b0, ws = 1'b0, wv = 1'b0, crc = 1'b0;
  logic done, crco, busy, vld, lst, pwe, flag, wdone;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, pnext, v;
  logic [6:0] r3o;
  logic [2:0] c3o;
  pfc_image_t img = '{7'h03, 3'h2, 2'h3, 2'h0, 8'hA5, 8'hFE}, imgo;
  int n_fail = 0, checks_done = 0;
  // ==========================================================================
  // Clock, device and loader
  always #20 sys_clk_i = ~sys_clk_i;
  pfc_regs uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rd_valid_o(vld), .reg_busy_o(busy), .load_request_bit_i(lreq),
    .load_done_i(done), .load_image_i(imgo), .crc_mismatch_i(crco),
    .prog_done_i(pdone), .load_start_o(lst), .prog_count_next_o(pnext),
    .prog_count_we_o(pwe), .crc_mismatch_flag_o(flag),
    .filter_r3_select_o(r3o), .filter_c3_select_o(c3o),
    .cal_wait_start_i(ws), .cal_wait_vco_i(wv), .cal_wait_done_o(wdone));
  pfc_loader_model ldr (.sys_clk_i(sys_clk_i), .load_start_i(lst),
    .img_i(img), .crc_i(crc), .load_done_o(done), .img_o(imgo), .crc_o(crco));
  // ==========================================================================
  // Shared tasks
  task conclude;
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i); wr = 1'b1; addr = a; wd = d;
    @(negedge sys_clk_i); wr = 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(negedge sys_clk_i); rd = 1'b1; addr = a;
    @(negedge sys_clk_i); rd = 1'b0;
    v = (vld === 1'b1) ? rdat : 8'hXX;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    chk($sformatf("reg_%h", a), v, e);
  endtask
  task wait_idle;
    for (int i = 0; i < 40; i++) begin
      if (busy === 1'b0) return;
      @(negedge sys_clk_i);
    end
    n_fail++;
    conclude();
  endtask
  // ==========================================================================
  // Scenarios
  task t_boot;
    rd_reg(PFC_OFS_R3);
    chk("busy_read_valid", vld, 1'b0);
    wait_idle();
    rd_chk(PFC_OFS_R3, 8'h03);
    rd_chk(PFC_OFS_C3, 8'h02);
    rd_chk(PFC_OFS_CAL, 8'h0C);
    rd_chk(PFC_OFS_SCRC, 8'hA5);
    rd_chk(PFC_OFS_CNT, 8'hFE);
    chk("crc_flag", flag, 1'b0);
  endtask
  task t_fields;
    wr_reg(PFC_OFS_R3, 8'hFF);
    rd_chk(PFC_OFS_R3, 8'h7F);
    chk("r3_out", r3o, 7'h7F);
    wr_reg(PFC_OFS_R3, 8'h14);
    chk("r3_out", r3o, 7'h14);
    wr_reg(PFC_OFS_C3, 8'hFD);
    rd_chk(PFC_OFS_C3, 8'h05);
    chk("c3_out", c3o, 3'h5);
    wr_reg(PFC_OFS_CAL, 8'hF6);
    rd_chk(PFC_OFS_CAL, 8'h06);
    wr_reg(PFC_OFS_SCRC, 8'h00);
    wr_reg(PFC_OFS_CNT, 8'h00);
    rd_chk(PFC_OFS_SCRC, 8'hA5);
    rd_chk(PFC_OFS_CNT, 8'hFE);
    rd_chk(8'h31, 8'h00);
  endtask
  task t_count;
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk_i); pdone = 1'b1;
      #1 chk("prog_we", pwe, 1'b1);
      chk("prog_next", pnext, 8'hFF);
      @(negedge sys_clk_i); pdone = 1'b0;
      rd_chk(PFC_OFS_CNT, 8'hFF);
    end
  endtask
  task t_reload;
    // The stored waits keep the recommended codes 2 and 1.
    img = '{7'h08, 3'h7, 2'h2, 2'h1, 8'h3C, 8'h01};
    crc = 1'b1;
    @(negedge sys_clk_i); lreq = 1'b1;
    @(negedge sys_clk_i); lreq = 1'b0;
    wait_idle();
    chk("crc_flag", flag, 1'b1);
    rd_chk(PFC_OFS_CNT, 8'h01);
    rd_chk(PFC_OFS_CAL, 8'h09);
    chk("r3_out", r3o, 7'h08);
  endtask
  task t_wait(input logic vco, input logic [7:0] code, input int us);
    int k;
    wr_reg(PFC_OFS_CAL, code);
    @(negedge sys_clk_i); ws = 1'b1; wv = vco;
    @(negedge sys_clk_i); ws = 1'b0;
    for (k = 1; k < us * PFC_CLK_MHZ + 9; k++) begin
      @(negedge sys_clk_i);
      if (wdone === 1'b1) break;
    end
    chk("wait_cycles", k, us * PFC_CLK_MHZ);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    t_boot();
    t_fields();
    t_count();
    t_reload();
    t_wait(1'b1, 8'h00, 20);
    t_wait(1'b0, 8'h00, 150);
    t_wait(1'b1, 8'h01, 400);
    conclude();
  end
endmodule // tb
